// ---- cdsc_pkg.sv ----
// Package: register map, field layout and timing constants for cdsc block
package cdsc_pkg;
    // Register byte addresses
    localparam logic [11:0] ADDR_DIV_CTRL = 12'h000;
    localparam logic [11:0] ADDR_MODE_CTRL = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_WAKE_CTRL = 12'h00C;
    // Divider control fields
    localparam int UNLOCK_BIT = 7;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 4;
    localparam logic [3:0] SEL_RESET_PLAIN = 4'h0;
    localparam logic [3:0] SEL_RESET_DIV8 = 4'h3;
    localparam logic [3:0] SEL_MAX = 4'h8;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    // Mode control fields
    localparam int PERMIT_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int MODE_W = 3;
    // Wake timing
    localparam logic [7:0] WAKE_HALT_CYCLES = 8'h04;
    localparam logic [7:0] STARTUP_RESET = 8'h06;

    typedef enum logic [2:0] {
        CDSC_MODE_IDLE = 3'b000,
        CDSC_MODE_ADC_NR = 3'b001,
        CDSC_MODE_PWR_DOWN = 3'b010,
        CDSC_MODE_PWR_SAVE = 3'b011,
        CDSC_MODE_STANDBY = 3'b110
    } cdsc_mode_t;

    typedef enum logic [1:0] {
        CDSC_ST_RUN = 2'b00,
        CDSC_ST_SLEEP = 2'b01,
        CDSC_ST_WAKE = 2'b10
    } cdsc_state_t;
endpackage

// ---- cdsc_top.sv ----
// Clock divider and sleep control with APB register access
//
// Notes on behaviour
// - Unlock bit sets only when the same write zeroes bits 6..0 of the low byte.
// - Divider select accepted only while the unlock bit is set.
// - Unlock clears four cycles after setting, or when select written.
// - Rewriting unlock during its window neither restarts nor clears it.
// - Select 0..8 divides by two to that power; 9..15 reserved.
// - Divided clock enable drives core and all synchronous peripherals.
// - Reset select is 0000, or 0011 when the div-by-eight fuse is set.
// - After unlock any select value is accepted regardless of the fuse.
// - Sleep entered only when sleep instruction runs with permit set.
// - Mode field: 000 idle,001 adc,010 down,011 save,110 standby.
// - Interrupt wake halts core four cycles beyond start-up time.
// - Register file and SRAM contents kept across sleep.
// - Reset during sleep wakes device and starts at reset vector.
// - Idle stops core and program memory clocks; peripherals run.
// - Idle wakes on external and internal interrupts.
// - Entering idle with converter enabled starts a conversion.
// - Divider change gives no glitch nor faster intermediate clock.
`timescale 1ns/100ps
module cdsc_top #(
    parameter int SEL_WIDTH = 4,
    parameter int DIV_CNT_W = 8
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Fuse and core interface
    input wire logic initial_div_by_eight_fuse_i,
    input wire logic sleep_instr_i,
    input wire logic irq_pending_i,
    input wire logic adc_enabled_i,
    // Clock enables and sleep status
    output logic core_clock_en_o,
    output logic program_memory_clock_en_o,
    output logic periph_clock_en_o,
    output logic [2:0] active_mode_o,
    output logic sleeping_o,
    output logic adc_start_o,
    output logic wake_irq_o
);
    logic [SEL_WIDTH-1:0] divider_select;
    logic [SEL_WIDTH-1:0] applied_select;
    logic divider_change_unlock;
    logic [2:0] unlock_cnt;
    logic sleep_permit;
    logic [2:0] low_power_mode_select;
    logic [7:0] startup_cycles;
    logic [DIV_CNT_W-1:0] div_cnt;
    logic fuse_loaded;
    logic [7:0] wake_cnt;
    cdsc_pkg::cdsc_state_t state;
    cdsc_pkg::cdsc_state_t next_state;
    logic div_tick;
    logic core_run;
    logic wr_access;
    logic rd_access;
    logic wr_div;
    logic unlock_req;
    logic sel_write;
    logic [DIV_CNT_W-1:0] div_mask;
    logic [31:0] next_rdata;
    logic addr_ok;
    logic wr_mode;
    logic wr_wake;
    logic unlock_expired;
    logic sleep_entry;
    logic wake_exit;

    assign wr_access = psel_i && penable_i && pwrite_i && pready_o;
    assign rd_access = psel_i && !penable_i && !pwrite_i;
    assign wr_div = wr_access && pstrb_i[0]
        && paddr_i == cdsc_pkg::ADDR_DIV_CTRL;
    assign unlock_req = wr_div && pwdata_i[7:0] == 8'h80;
    assign sel_write = wr_div && !pwdata_i[cdsc_pkg::UNLOCK_BIT]
        && divider_change_unlock;
    assign addr_ok = paddr_i == cdsc_pkg::ADDR_DIV_CTRL
        || paddr_i == cdsc_pkg::ADDR_MODE_CTRL
        || paddr_i == cdsc_pkg::ADDR_STATUS
        || paddr_i == cdsc_pkg::ADDR_WAKE_CTRL;

    // APB: no wait state, answer in first access cycle
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= psel_i && !penable_i;
        end
    end

    // Unmapped offsets answer with an error, same cycle as ready
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= psel_i && !penable_i && !addr_ok;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr_i)
            cdsc_pkg::ADDR_DIV_CTRL: begin
                next_rdata[cdsc_pkg::UNLOCK_BIT] = divider_change_unlock;
                next_rdata[SEL_WIDTH-1:0] = divider_select;
            end
            cdsc_pkg::ADDR_MODE_CTRL: begin
                next_rdata[cdsc_pkg::PERMIT_BIT] = sleep_permit;
                next_rdata[3:1] = low_power_mode_select;
            end
            cdsc_pkg::ADDR_STATUS: begin
                next_rdata[1:0] = state;
                next_rdata[7:4] = applied_select;
            end
            cdsc_pkg::ADDR_WAKE_CTRL: begin
                next_rdata[7:0] = startup_cycles;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_access) begin
            prdata_o <= next_rdata;
        end
    end

    // Unlock window
    assign unlock_expired = divider_change_unlock
        && unlock_cnt == cdsc_pkg::UNLOCK_CYCLES - 3'h1;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            divider_change_unlock <= 1'b0;
        end else if (sel_write) begin
            divider_change_unlock <= 1'b0;
        end else if (unlock_expired) begin
            divider_change_unlock <= 1'b0;
        end else if (unlock_req && !divider_change_unlock) begin
            divider_change_unlock <= 1'b1;
        end
    end

    // Window count runs on; a second unlock write cannot restart it
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            unlock_cnt <= 3'h0;
        end else if (divider_change_unlock) begin
            unlock_cnt <= unlock_cnt + 3'h1;
        end else begin
            unlock_cnt <= 3'h0;
        end
    end

    // Fuse value caught at the first edge after reset release
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fuse_loaded <= 1'b0;
        end else begin
            fuse_loaded <= 1'b1;
        end
    end

    // Select register
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            divider_select <= cdsc_pkg::SEL_RESET_PLAIN;
        end else if (!fuse_loaded) begin
            divider_select <= initial_div_by_eight_fuse_i
                ? cdsc_pkg::SEL_RESET_DIV8
                : cdsc_pkg::SEL_RESET_PLAIN;
        end else if (sel_write) begin
            divider_select <= pwdata_i[SEL_WIDTH-1:0];
        end
    end

    assign wr_mode = wr_access && pstrb_i[0]
        && paddr_i == cdsc_pkg::ADDR_MODE_CTRL;
    assign wr_wake = wr_access && pstrb_i[0]
        && paddr_i == cdsc_pkg::ADDR_WAKE_CTRL;

    // Mode control register
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sleep_permit <= 1'b0;
            low_power_mode_select <= 3'h0;
        end else if (wr_mode) begin
            sleep_permit <= pwdata_i[cdsc_pkg::PERMIT_BIT];
            low_power_mode_select <= pwdata_i[cdsc_pkg::MODE_LSB
                +: cdsc_pkg::MODE_W];
        end
    end

    // Start-up time register
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            startup_cycles <= cdsc_pkg::STARTUP_RESET;
        end else if (wr_wake) begin
            startup_cycles <= pwdata_i[7:0];
        end
    end

    // Divider mask; reserved codes clamp to the largest factor
    always_comb begin
        if (applied_select > cdsc_pkg::SEL_MAX) begin
            div_mask = {DIV_CNT_W{1'b1}};
        end else begin
            div_mask = DIV_CNT_W'((1 << applied_select) - 1);
        end
    end

    assign div_tick = (div_cnt & div_mask) == '0;

    // New factor applied only at a period boundary: no glitch
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_cnt <= '0;
            applied_select <= cdsc_pkg::SEL_RESET_PLAIN;
        end else begin
            if (div_tick) begin
                applied_select <= divider_select;
                div_cnt <= DIV_CNT_W'(1);
            end else begin
                div_cnt <= div_cnt + DIV_CNT_W'(1);
            end
        end
    end

    // Sleep state machine
    always_comb begin
        next_state = state;
        case (state)
            cdsc_pkg::CDSC_ST_RUN: begin
                if (sleep_instr_i && sleep_permit) begin
                    next_state = cdsc_pkg::CDSC_ST_SLEEP;
                end
            end
            cdsc_pkg::CDSC_ST_SLEEP: begin
                if (irq_pending_i) begin
                    next_state = cdsc_pkg::CDSC_ST_WAKE;
                end
            end
            cdsc_pkg::CDSC_ST_WAKE: begin
                if (wake_cnt == 8'h00) begin
                    next_state = cdsc_pkg::CDSC_ST_RUN;
                end
            end
            default: begin
                next_state = cdsc_pkg::CDSC_ST_RUN;
            end
        endcase
    end

    // Reset during sleep returns to run state at the reset vector
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= cdsc_pkg::CDSC_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_cnt <= 8'h00;
        end else if (state == cdsc_pkg::CDSC_ST_SLEEP && irq_pending_i) begin
            wake_cnt <= 8'(startup_cycles + cdsc_pkg::WAKE_HALT_CYCLES
                - 8'h01);
        end else if (wake_cnt != 8'h00) begin
            wake_cnt <= wake_cnt - 8'h01;
        end
    end

    assign core_run = next_state == cdsc_pkg::CDSC_ST_RUN;
    assign sleep_entry = state == cdsc_pkg::CDSC_ST_RUN
        && next_state == cdsc_pkg::CDSC_ST_SLEEP;
    assign wake_exit = state == cdsc_pkg::CDSC_ST_WAKE
        && next_state == cdsc_pkg::CDSC_ST_RUN;

    // Core and program memory enables; core stops but state is held
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_clock_en_o <= 1'b0;
            program_memory_clock_en_o <= 1'b0;
        end else begin
            core_clock_en_o <= core_run && div_tick;
            program_memory_clock_en_o <= core_run && div_tick;
        end
    end

    // Peripheral tick keeps running only in idle
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            periph_clock_en_o <= 1'b0;
        end else begin
            periph_clock_en_o <= div_tick && (core_run
                || low_power_mode_select
                == cdsc_pkg::CDSC_MODE_IDLE);
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            active_mode_o <= 3'h0;
        end else if (sleep_entry) begin
            active_mode_o <= low_power_mode_select;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sleeping_o <= 1'b0;
        end else begin
            sleeping_o <= !core_run;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            adc_start_o <= 1'b0;
        end else begin
            adc_start_o <= sleep_entry && adc_enabled_i
                && low_power_mode_select
                == cdsc_pkg::CDSC_MODE_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_irq_o <= 1'b0;
        end else begin
            wake_irq_o <= wake_exit;
        end
    end
endmodule

// ---- cdsc_sva.sv ----
// Assertions on APB handshake, sleep entry and wake timing of cdsc_top
`timescale 1ns/100ps
module cdsc_sva #(
    parameter int SEL_WIDTH = 4,
    parameter int DIV_CNT_W = 8
) (
    // Clock, reset and APB
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Core side
    input wire logic sleep_instr_i,
    input wire logic irq_pending_i,
    input wire logic core_clock_en_o,
    input wire logic program_memory_clock_en_o,
    input wire logic periph_clock_en_o,
    input wire logic [2:0] active_mode_o,
    input wire logic sleeping_o,
    input wire logic adc_start_o,
    input wire logic wake_irq_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    chk_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    chk_sleep_cause: assert property (
        $rose(sleeping_o) |-> $past(sleep_instr_i))
        else $error("sleep without instruction");
    chk_core_halt: assert property (
        sleeping_o |-> !core_clock_en_o && !program_memory_clock_en_o)
        else $error("core clock runs in sleep");
    chk_periph_gate: assert property (
        sleeping_o && active_mode_o != 3'b000 |-> !periph_clock_en_o)
        else $error("peripheral tick outside idle");
    chk_wake_hold: assert property (
        $rose(irq_pending_i) && sleeping_o |=> !core_clock_en_o [*8])
        else $error("core resumed too early");
    chk_wake_time: assert property (
        $rose(irq_pending_i) && sleeping_o |-> ##[9:14] wake_irq_o)
        else $error("wake not signalled in time");
    chk_adc_entry: assert property (
        adc_start_o |-> ##[0:1] (sleeping_o && active_mode_o == 3'b000))
        else $error("conversion start outside sleep entry");
    cover property ($rose(sleeping_o));
    cover property (wake_irq_o);
    cover property (pslverr_o);
    cover property (adc_start_o);
endmodule

bind cdsc_top cdsc_sva #(.SEL_WIDTH(SEL_WIDTH), .DIV_CNT_W(DIV_CNT_W)) u_cdsc_sva (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sleep_instr_i(sleep_instr_i), .irq_pending_i(irq_pending_i),
    .core_clock_en_o(core_clock_en_o),
    .program_memory_clock_en_o(program_memory_clock_en_o),
    .periph_clock_en_o(periph_clock_en_o), .active_mode_o(active_mode_o),
    .sleeping_o(sleeping_o), .adc_start_o(adc_start_o),
    .wake_irq_o(wake_irq_o));

// ---- tb.sv ----
// Self-checking bench of the clock divider and sleep control
`timescale 1ns/100ps
module tb;
    logic ref_clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o;
    logic pslverr_o, fuse, sleep_instr_i, irq_pending_i, adc_enabled_i;
    logic core_en, pm_en, per_en, sleeping_o, adc_start_o, wake_irq_o, err;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, q, rs;
    logic [3:0] pstrb_i, s;
    logic [2:0] active_mode_o, m;
    logic [2:0] modes [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b110};
    int n_mismatch = 0, checked = 0, n_adc = 0, a0, p, n;
    cdsc_top u_cdsc_top (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .initial_div_by_eight_fuse_i(fuse), .sleep_instr_i(sleep_instr_i),
        .irq_pending_i(irq_pending_i), .adc_enabled_i(adc_enabled_i),
        .core_clock_en_o(core_en), .program_memory_clock_en_o(pm_en),
        .periph_clock_en_o(per_en), .active_mode_o(active_mode_o),
        .sleeping_o(sleeping_o), .adc_start_o(adc_start_o),
        .wake_irq_o(wake_irq_o));
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) if (adc_start_o === 1'b1) n_adc++;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic int exp_per(input logic [3:0] v);
        return 1 << v;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
        n = 0;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 1, 0);
        q = prdata_o;
        err = pslverr_o;
        penable_i <= 1'b0;
        psel_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, logic [31:0] e, string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, q & 32'hFF);
    endtask
    task automatic per();
        n = 0;
        p = 0;
        do begin @(negedge ref_clk_i); n++; end
            while (core_en !== 1'b1 && n < 600);
        do begin @(negedge ref_clk_i); p++; end
            while (core_en !== 1'b1 && p < 600);
    endtask
    task automatic slp();
        @(posedge ref_clk_i) sleep_instr_i <= 1'b1;
        @(posedge ref_clk_i) sleep_instr_i <= 1'b0;
        @(negedge ref_clk_i);
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        {psel_i, penable_i, pwrite_i, sleep_instr_i, irq_pending_i} = '0;
        {reset_n_i, adc_enabled_i, paddr_i, pwdata_i} = '0;
        fuse = 1'b1;
        pstrb_i = 4'hF;
        rs = 32'hC02F;
        repeat (20) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rd(12'h000, 32'h03, "sel_reset");
        apb(1'b1, 12'h000, 32'h05);
        rd(12'h000, 32'h03, "sel_locked");
        apb(1'b1, 12'h000, 32'h81);
        apb(1'b1, 12'h000, 32'h05);
        rd(12'h000, 32'h03, "unlock_dirty");
        apb(1'b1, 12'h000, 32'h80);
        apb(1'b1, 12'h000, 32'h80);
        apb(1'b1, 12'h000, 32'h05);
        rd(12'h000, 32'h03, "unlock_rewrite");
        apb(1'b1, 12'h010, rs);
        chk("unmapped_err", 1, err);
        rd(12'h010, 32'h00, "unmapped_rd");
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            rs = xs(rs);
            s = (i == 0) ? 4'h8 : (i == 4) ? 4'h0 : 4'(rs % 9);
            apb(1'b1, 12'h000, 32'h80);
            apb(1'b1, 12'h000, {28'h0, s});
            rd(12'h000, {28'h0, s}, "sel_new");
            per();
            per();
            chk("period", exp_per(s), p);
        end
        apb(1'b1, 12'h000, 32'h02);
        rd(12'h000, 32'h00, "sel_relock");
        $display("test divider done");
        for (int i = 0; i < 5; i++) begin
            m = modes[i];
            rs = xs(rs);
            adc_enabled_i <= rs[0];
            a0 = n_adc;
            apb(1'b1, 12'h004, {28'h0, m, 1'b1});
            slp();
            chk("sleeping", 1, sleeping_o);
            chk("mode", m, active_mode_o);
            chk("core_halt", 0, {core_en, pm_en});
            p = 0;
            repeat (8) @(negedge ref_clk_i) p += (per_en === 1'b1);
            chk("periph", m == 3'b000, p > 0);
            chk("adc", m == 3'b000 && rs[0], n_adc - a0);
            @(posedge ref_clk_i) irq_pending_i <= 1'b1;
            n = 0;
            do begin @(negedge ref_clk_i); n++; end
                while (wake_irq_o !== 1'b1 && n < 40);
            chk("wake", 1, n >= 10 && n <= 13);
            @(posedge ref_clk_i) irq_pending_i <= 1'b0;
            apb(1'b1, 12'h004, {28'h0, m, 1'b0});
        end
        apb(1'b1, 12'h004, 32'h00);
        slp();
        chk("nop_sleep", 0, sleeping_o);
        chk("core_runs", 1, core_en);
        chk("pm_runs", 1, pm_en);
        $display("test sleep done");
        apb(1'b1, 12'h004, 32'h05);
        slp();
        @(posedge ref_clk_i) reset_n_i <= 1'b0;
        fuse <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(negedge ref_clk_i);
        chk("reset_wake", 0, sleeping_o);
        rd(12'h000, 32'h00, "sel_reset_plain");
        $display("test reset done");
        finish_test();
    end
endmodule
